/* File: exc_pkg.sv */
package exc_pkg;
	// ****************************************
	// sizes
	// ****************************************
	localparam int NUM_SRC = 21;
	localparam int PRESCALE_W = 12;
	localparam logic [15:0] STACK_TOP = 16'h00FF;
	localparam logic [15:0] CPU_SP_RESET = 16'h00FF;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [3:0] OFS_PEND_LOW = 4'h0;
	localparam logic [3:0] OFS_PEND_MID = 4'h1;
	localparam logic [3:0] OFS_PEND_HIGH = 4'h2;
	localparam logic [3:0] OFS_ENABLE_LOW = 4'h3;
	localparam logic [3:0] OFS_ENABLE_MID = 4'h4;
	localparam logic [3:0] OFS_ENABLE_HIGH = 4'h5;
	localparam logic [3:0] OFS_CPU_STATUS = 4'h6;
	localparam logic [3:0] OFS_PRESCALE_LO = 4'h7;
	localparam logic [3:0] OFS_PRESCALE_HI = 4'h8;
	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int PEND_LOW_LSB = 2;
	localparam int PEND_MID_FIRST = 6;
	localparam int PEND_HIGH_FIRST = 14;
	localparam int STAT_MASK_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_SWI_BIT = 2;
	localparam logic [20:0] ENABLE_RESET = 21'h000000;
	// ****************************************
	// vectors
	// ****************************************
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_SWI = 16'hFFFC;
	localparam logic [15:0] VEC_FLAG1 = 16'hFFFA;
	localparam logic [15:0] VEC_RESERVED = 16'hFFD0;
	localparam logic [15:0] VEC_STEP = 16'h0002;
	// ****************************************
	// sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		ST_RUN,
		ST_PUSH,
		ST_FETCH_HI,
		ST_FETCH_LO,
		ST_POP
	} seq_e;
endpackage

/* File: prio_pick.sv */
`timescale 1ns/100ps
// fixed priority: lowest index wins
module prio_pick
	import exc_pkg::*;
(
	input wire logic [20:0] req,
	output logic found,
	output logic [4:0] index
);
	always_comb begin
		found = 1'b0;
		index = 5'h00;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				found = 1'b1;
				index = 5'(i);
			end
		end
	end
endmodule

/* File: exception_arbiter.sv */
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module exception_arbiter
	import exc_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic INTERNAL_RESET,
	input wire logic [20:0] IRQ_REQ,
	input wire logic INSTR_END,
	input wire logic SWI_EXEC,
	input wire logic RTI_EXEC,
	input wire logic [15:0] PC_IN,
	input wire logic [7:0] CCR_IN,
	input wire logic [7:0] ACC_IN,
	input wire logic [7:0] X_IN,
	input wire logic [7:0] MEM_RDATA,
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [7:0] REG_RDATA,
	output logic [15:0] MEM_ADDR,
	output logic [7:0] MEM_WDATA,
	output logic MEM_WR,
	output logic MEM_RD,
	output logic CPU_HOLD,
	output logic CPU_LOAD,
	output logic DISCARD_PREFETCH,
	output logic [15:0] PC_OUT,
	output logic [7:0] CCR_OUT,
	output logic [7:0] ACC_OUT,
	output logic [7:0] X_OUT,
	output logic MASK_BIT,
	output logic [15:0] VECTOR_ADDR,
	output logic [11:0] PRESCALE
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		seq_e st;
		logic [2:0] step;
		logic [15:0] sp;
		logic [20:0] enable;
		logic [20:0] sync1;
		logic [20:0] sync2;
		logic [20:0] sync3;
		logic [20:0] req;
		logic latched;
		logic [4:0] lat_idx;
		logic lat_swi;
		logic lat_reset;
		logic [15:0] vec;
		logic mask;
		logic [7:0] rdata;
		logic [15:0] maddr;
		logic [7:0] mwdata;
		logic mwr;
		logic mrd;
		logic hold;
		logic load;
		logic discard;
		logic [15:0] pc;
		logic [7:0] ccr;
		logic [7:0] acc;
		logic [7:0] x;
	} core_s;

	core_s q, d;
	logic [11:0] prescale_q;
	logic [11:0] prescale_d;
	logic pick_found;
	logic [4:0] pick_idx;
	logic [20:0] eligible;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [15:0] flag_vector(input logic [4:0] idx);
		flag_vector = VEC_FLAG1 - 16'(VEC_STEP * 16'(idx));
	endfunction

	function automatic logic [7:0] status_byte(input logic [3:0] a, input logic [20:0] r,
		input logic [20:0] en, input core_s s);
		case (a)
			OFS_PEND_LOW: status_byte = {r[5:0], 2'b00};
			OFS_PEND_MID: status_byte = r[13:6];
			OFS_PEND_HIGH: status_byte = {1'b0, r[20:14]};
			OFS_ENABLE_LOW: status_byte = en[7:0];
			OFS_ENABLE_MID: status_byte = en[15:8];
			OFS_ENABLE_HIGH: status_byte = {3'b000, en[20:16]};
			OFS_CPU_STATUS: status_byte = {5'b00000, s.lat_swi, s.latched, s.mask};
			default: status_byte = 8'h00;
		endcase
	endfunction

	assign eligible = q.enable & q.req & {NUM_SRC{~q.mask}};

	prio_pick pick_u (
		.req(eligible),
		.found(pick_found),
		.index(pick_idx)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		d = q;
		d.sync1 = IRQ_REQ;
		d.sync2 = q.sync1;
		d.sync3 = q.sync2;
		// request line counts once two stages agree
		for (int i = 0; i < NUM_SRC; i++) begin
			if (q.sync2[i] == q.sync3[i]) begin
				d.req[i] = q.sync3[i];
			end
		end
		d.rdata = 8'h00;
		d.mwr = 1'b0;
		d.mrd = 1'b0;
		d.load = 1'b0;
		d.discard = 1'b0;
		if (REG_RD) begin
			d.rdata = status_byte(REG_ADDR, q.req, q.enable, q);
		end
		// pending registers are read only
		if (REG_WR) begin
			case (REG_ADDR)
				OFS_ENABLE_LOW: d.enable[7:0] = REG_WDATA;
				OFS_ENABLE_MID: d.enable[15:8] = REG_WDATA;
				OFS_ENABLE_HIGH: d.enable[20:16] = REG_WDATA[4:0];
				OFS_CPU_STATUS: d.mask = REG_WDATA[STAT_MASK_BIT];
				default: d.mask = q.mask;
			endcase
		end
		case (q.st)
			ST_RUN: begin
				d.hold = 1'b0;
				if (q.lat_reset) begin
					d.lat_reset = 1'b0;
					d.vec = VEC_RESET;
					d.st = ST_FETCH_HI;
					d.hold = 1'b1;
				end else if (INSTR_END && RTI_EXEC) begin
					d.st = ST_POP;
					d.step = 3'd0;
					d.sp = q.sp + 16'h0001;
					d.hold = 1'b1;
				end else if (INSTR_END && SWI_EXEC) begin
					d.lat_swi = 1'b1;
					d.latched = 1'b1;
					d.vec = VEC_SWI;
					d.pc = PC_IN;
					d.st = ST_PUSH;
					d.step = 3'd0;
					d.hold = 1'b1;
				end else if (INSTR_END && pick_found) begin
					d.lat_swi = 1'b0;
					d.latched = 1'b1;
					d.lat_idx = pick_idx;
					d.vec = flag_vector(pick_idx);
					d.pc = PC_IN - 16'h0001;
					d.st = ST_PUSH;
					d.step = 3'd0;
					d.hold = 1'b1;
				end
			end
			ST_PUSH: begin
				d.mwr = 1'b1;
				d.maddr = q.sp;
				d.sp = q.sp - 16'h0001;
				d.step = q.step + 3'd1;
				case (q.step)
					3'd0: d.mwdata = q.pc[7:0];
					3'd1: d.mwdata = q.pc[15:8];
					3'd2: d.mwdata = X_IN;
					3'd3: d.mwdata = ACC_IN;
					default: begin
						d.mwdata = CCR_IN;
						d.mask = 1'b1;
						d.st = ST_FETCH_HI;
					end
				endcase
			end
			ST_FETCH_HI: begin
				d.mrd = 1'b1;
				d.maddr = q.vec;
				d.st = ST_FETCH_LO;
				d.step = 3'd0;
			end
			ST_FETCH_LO: begin
				// memory answers two edges after the read is issued
				if (q.step == 3'd0) begin
					d.mrd = 1'b1;
					d.maddr = q.vec + 16'h0001;
					d.step = 3'd1;
				end else if (q.step == 3'd1) begin
					d.pc[15:8] = MEM_RDATA;
					d.step = 3'd2;
				end else begin
					d.pc[7:0] = MEM_RDATA;
					d.load = 1'b1;
					d.latched = 1'b0;
					d.lat_swi = 1'b0;
					d.st = ST_RUN;
					d.hold = 1'b0;
				end
			end
			ST_POP: begin
				d.step = q.step + 3'd1;
				// five reads, each captured two edges after it is issued
				if (q.step <= 3'd4) begin
					d.mrd = 1'b1;
					d.maddr = q.sp;
				end
				if (q.step < 3'd4) begin
					d.sp = q.sp + 16'h0001;
				end
				case (q.step)
					3'd2: d.ccr = MEM_RDATA;
					3'd3: d.acc = MEM_RDATA;
					3'd4: d.x = MEM_RDATA;
					3'd5: d.pc[15:8] = MEM_RDATA;
					3'd6: begin
						d.pc[7:0] = MEM_RDATA;
						d.mask = q.ccr[3];
						d.load = 1'b1;
						d.discard = 1'b1;
						d.st = ST_RUN;
						d.hold = 1'b0;
					end
					default: d.ccr = q.ccr;
				endcase
			end
			default: d.st = ST_RUN;
		endcase
		prescale_d = prescale_q + 12'h001;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			q <= '0;
			q.sp <= CPU_SP_RESET;
			q.mask <= 1'b1;
			q.lat_reset <= 1'b1;
			q.hold <= 1'b1;
			q.vec <= VEC_RESET;
		end else if (INTERNAL_RESET) begin
			q <= '0;
			q.sp <= CPU_SP_RESET;
			q.mask <= 1'b1;
			q.lat_reset <= 1'b1;
			q.hold <= 1'b1;
			q.vec <= VEC_RESET;
		end else begin
			q <= d;
		end
	end

	// external reset pin does not reach this counter
	always_ff @(posedge CLK_SYS) begin
		if (INTERNAL_RESET) begin
			prescale_q <= 12'h000;
		end else begin
			prescale_q <= prescale_d;
		end
	end

	assign REG_RDATA = q.rdata;
	assign MEM_ADDR = q.maddr;
	assign MEM_WDATA = q.mwdata;
	assign MEM_WR = q.mwr;
	assign MEM_RD = q.mrd;
	assign CPU_HOLD = q.hold;
	assign CPU_LOAD = q.load;
	assign DISCARD_PREFETCH = q.discard;
	assign PC_OUT = q.pc;
	assign CCR_OUT = {q.ccr[7:4], q.mask, q.ccr[2:0]};
	assign ACC_OUT = q.acc;
	assign X_OUT = q.x;
	assign MASK_BIT = q.mask;
	assign VECTOR_ADDR = q.vec;
	assign PRESCALE = prescale_q;
endmodule

/* File: exc_mem.sv */
`timescale 1ns/100ps
module exc_mem (
	input wire logic clk,
	input wire logic rd,
	input wire logic wr,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] ram [256];
	initial rdata = 8'h00;
	// vector bytes echo their low address; idle bus toggles
	always @(posedge clk) begin
		if (wr) begin
			ram[addr[7:0]] <= wdata;
		end
		if (!rd) begin
			rdata <= ~rdata;
		end else if (addr[15:8] == 8'hFF) begin
			rdata <= addr[7:0];
		end else begin
			rdata <= ram[addr[7:0]];
		end
	end
endmodule

/* File: exception_arbiter_assertions.sv */
`timescale 1ns/100ps
module exception_arbiter_chk
	import exc_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic INTERNAL_RESET,
	input wire logic INSTR_END,
	input wire logic SWI_EXEC,
	input wire logic [15:0] PC_IN,
	input wire logic [3:0] REG_ADDR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic [15:0] MEM_ADDR,
	input wire logic [7:0] MEM_WDATA,
	input wire logic MEM_WR,
	input wire logic MEM_RD,
	input wire logic CPU_HOLD,
	input wire logic MASK_BIT,
	input wire logic [15:0] VECTOR_ADDR,
	input wire logic [11:0] PRESCALE
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	logic [7:0] pc_lo;
	logic swi_go;
	assign pc_lo = PC_IN[7:0];
	assign swi_go = INSTR_END && SWI_EXEC && !CPU_HOLD;
	a_prescale_runs: assert property (!INTERNAL_RESET |=> INTERNAL_RESET ||
		PRESCALE == $past(PRESCALE) + 12'h001) else $error("prescale stalled");
	a_prescale_clear: assert property (INTERNAL_RESET |=> PRESCALE == 12'h000)
		else $error("prescale not cleared");
	a_reset_vector: assert property (INTERNAL_RESET |=> VECTOR_ADDR == VEC_RESET)
		else $error("reset vector not selected");
	a_low_bits_zero: assert property (REG_RD && REG_ADDR == OFS_PEND_LOW
		|=> REG_RDATA[1:0] == 2'b00) else $error("low status bits set");
	a_swi_push: assert property (swi_go |=> ##1 MEM_WR [*5] ##1 !MEM_WR)
		else $error("software entry push count wrong");
	a_swi_pc: assert property (swi_go |=> ##1 MEM_WDATA == $past(pc_lo, 2))
		else $error("software entry stacked wrong pc");
	a_mask_after_push: assert property ($fell(MEM_WR) |-> ##[0:3] MASK_BIT)
		else $error("mask not set after stacking");
	a_vector_pair: assert property (MEM_RD && MEM_ADDR[15:8] == 8'hFF && !MEM_ADDR[0]
		|=> MEM_RD && MEM_ADDR == $past(MEM_ADDR) + 16'h0001) else $error("vector pair");
	a_hold_busy: assert property (MEM_WR || MEM_RD |-> CPU_HOLD)
		else $error("core not held during access");
	a_masked_none: assert property (MASK_BIT && INSTR_END && !SWI_EXEC && !CPU_HOLD
		|=> ##1 !MEM_WR) else $error("masked request taken");
endmodule
bind exception_arbiter exception_arbiter_chk i_chk (.*);

/* File: test_exception_arbiter.sv */
`timescale 1ns/100ps
module test_exception_arbiter
	import exc_pkg::*;
;
	logic CLK_SYS, RST, INTERNAL_RESET, INSTR_END, SWI_EXEC, RTI_EXEC, REG_WR, REG_RD;
	logic MEM_WR, MEM_RD, CPU_HOLD, CPU_LOAD, DISCARD_PREFETCH, MASK_BIT;
	logic [20:0] IRQ_REQ, r;
	logic [15:0] PC_IN, MEM_ADDR, PC_OUT, VECTOR_ADDR, pc, st;
	logic [7:0] CCR_IN, ACC_IN, X_IN, MEM_RDATA, REG_WDATA, REG_RDATA, MEM_WDATA;
	logic [7:0] CCR_OUT, ACC_OUT, X_OUT;
	logic [3:0] REG_ADDR;
	logic [11:0] PRESCALE, p;
	int n_errors, compares, i, k;
	exception_arbiter i_exception_arbiter (.*);
	exc_mem i_exc_mem (.clk(CLK_SYS), .rd(MEM_RD), .wr(MEM_WR), .addr(MEM_ADDR),
		.wdata(MEM_WDATA), .rdata(MEM_RDATA));
	initial begin
		CLK_SYS = 1'b0;
		forever #20 CLK_SYS = ~CLK_SYS;
	end
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (e !== g) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge CLK_SYS);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge CLK_SYS);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		#1;
		chk("reg", e, REG_RDATA);
	endtask
	task load(input logic [15:0] e);
		for (i = 0; i < 80; i++) begin
			@(posedge CLK_SYS);
			#1;
			if (CPU_LOAD === 1'b1) break;
		end
		chk("pc_out", e, PC_OUT);
	endtask
	task pulse(input logic s, input logic t);
		@(posedge CLK_SYS);
		INSTR_END <= 1'b1;
		SWI_EXEC <= s;
		RTI_EXEC <= t;
		@(posedge CLK_SYS);
		INSTR_END <= 1'b0;
		SWI_EXEC <= 1'b0;
		RTI_EXEC <= 1'b0;
	endtask
	task enter(input logic s, input logic [15:0] v);
		@(posedge CLK_SYS);
		pc = $urandom;
		st = s ? pc : pc - 16'h0001;
		PC_IN <= pc;
		pulse(s, 1'b0);
		load({v[7:0], v[7:0] + 8'h01});
		chk("vector", v, VECTOR_ADDR);
		chk("stack_pc", st, {i_exc_mem.ram[8'hFE], i_exc_mem.ram[8'hFF]});
		chk("mask", 16'h0001, MASK_BIT);
		IRQ_REQ <= '0;
		pulse(1'b0, 1'b1);
		load(st);
		chk("discard", 16'h0001, DISCARD_PREFETCH);
	endtask
	task idle(input logic [20:0] q);
		@(posedge CLK_SYS);
		IRQ_REQ <= q;
		repeat (4) @(posedge CLK_SYS);
		pulse(1'b0, 1'b0);
		repeat (3) @(posedge CLK_SYS);
		#1;
		chk("hold", 16'h0000, CPU_HOLD);
	endtask
	task results;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		n_errors++;
		results;
	end
	initial begin
		// internal reset at power-up gives the prescale counter a known start
		{RST, INTERNAL_RESET, INSTR_END, SWI_EXEC, RTI_EXEC, REG_WR, REG_RD} = 7'h60;
		{IRQ_REQ, PC_IN, CCR_IN, ACC_IN, X_IN, REG_WDATA, REG_ADDR} = '0;
		n_errors = 0;
		compares = 0;
		k = $urandom(32'h1423);
		repeat (5) @(posedge CLK_SYS);
		RST <= 1'b0;
		INTERNAL_RESET <= 1'b0;
		load(16'hFEFF);
		rd(OFS_ENABLE_LOW, 8'h00);
		rd(4'hF, 8'h00);
		for (k = 0; k < 6; k++) begin
			r = $urandom;
			idle(r);
			wr(OFS_PEND_MID, ~r[13:6]);
			rd(OFS_PEND_LOW, {r[5:0], 2'b00});
			rd(OFS_PEND_MID, r[13:6]);
			rd(OFS_PEND_HIGH, {1'b0, r[20:14]});
		end
		wr(OFS_ENABLE_LOW, 8'hFF);
		wr(OFS_ENABLE_MID, 8'hFF);
		wr(OFS_ENABLE_HIGH, 8'hFF);
		for (k = 0; k < 21; k++) begin
			wr(OFS_CPU_STATUS, 8'h00);
			@(posedge CLK_SYS);
			IRQ_REQ <= ($urandom << k) | (21'h1 << k);
			repeat (4) @(posedge CLK_SYS);
			enter(1'b0, VEC_FLAG1 - 16'(2 * k));
		end
		wr(OFS_CPU_STATUS, 8'h01);
		idle(21'h1);
		enter(1'b1, VEC_SWI);
		wr(OFS_CPU_STATUS, 8'h00);
		wr(OFS_ENABLE_LOW, 8'h00);
		idle(21'h1);
		@(posedge CLK_SYS);
		p = PRESCALE;
		RST <= 1'b1;
		repeat (3) @(posedge CLK_SYS);
		#1;
		chk("prescale_kept", {4'h0, p + 12'h004}, {4'h0, PRESCALE});
		RST <= 1'b0;
		load(16'hFEFF);
		INTERNAL_RESET <= 1'b1;
		repeat (2) @(posedge CLK_SYS);
		INTERNAL_RESET <= 1'b0;
		load(16'hFEFF);
		chk("prescale_low", 16'h0001, PRESCALE < 12'h064);
		results;
	end
endmodule
